// file: design/usc_regs.svh
// register offsets, field positions, reset values and counts for setup capture
// assumes it is included by bare name from the design file
`ifndef USC_REGS_SVH
`define USC_REGS_SVH

// byte addresses of the captured setup bytes, one aligned word each
`define USC_OFS_ATTRIBUTES   12'h480
`define USC_OFS_REQUEST_CODE 12'h484
`define USC_OFS_VALUE_LOW    12'h488
`define USC_OFS_VALUE_HIGH   12'h48C
`define USC_OFS_INDEX_LOW    12'h490
`define USC_OFS_INDEX_HIGH   12'h494
`define USC_OFS_LENGTH_LOW   12'h498
`define USC_OFS_LENGTH_HIGH  12'h49C

// block status and control words
`define USC_OFS_STATUS       12'h478
`define USC_OFS_CONTROL      12'h47C

// attribute byte fields
`define USC_ATTR_RCPT_MSB    4
`define USC_ATTR_RCPT_LSB    0
`define USC_ATTR_TYPE_MSB    6
`define USC_ATTR_TYPE_LSB    5
`define USC_ATTR_DIR_BIT     7

// status bits: packet captured, packet cut short
`define USC_STAT_CAPTURED    0
`define USC_STAT_SHORT       1

// control bits: capture enable, hold after capture
`define USC_CTRL_ENABLE      0
`define USC_CTRL_HOLD        1

// reset values
`define USC_RST_BYTE         8'h00
`define USC_RST_CONTROL      2'h1

// bytes in a setup packet
`define USC_SETUP_BYTES      8

`endif

// file: design/usc_pkg.sv
// types shared by the setup capture block
// assumes nothing beyond a SystemVerilog compiler
package usc_pkg;

    // standard request codes; class and vendor codes stay undecoded
    typedef enum logic [7:0] {
        USC_REQ_GET_STATUS        = 8'h00,
        USC_REQ_CLEAR_FEATURE     = 8'h01,
        USC_REQ_SET_FEATURE       = 8'h03,
        USC_REQ_SET_ADDRESS       = 8'h05,
        USC_REQ_GET_DESCRIPTOR    = 8'h06,
        USC_REQ_SET_DESCRIPTOR    = 8'h07,
        USC_REQ_GET_CONFIGURATION = 8'h08,
        USC_REQ_SET_CONFIGURATION = 8'h09,
        USC_REQ_GET_INTERFACE     = 8'h0A,
        USC_REQ_SET_INTERFACE     = 8'h0B,
        USC_REQ_SYNCH_FRAME       = 8'h0C
    } usc_request_t;

    // request type field of the attribute byte
    typedef enum logic [1:0] {
        USC_TYPE_STANDARD = 2'h0,
        USC_TYPE_CLASS    = 2'h1,
        USC_TYPE_VENDOR   = 2'h2
    } usc_req_type_t;

    // transfer direction
    typedef enum logic {
        USC_DIR_HOST_TO_DEVICE = 1'b0,
        USC_DIR_DEVICE_TO_HOST = 1'b1
    } usc_dir_t;

    // receive sequencer states
    typedef enum logic [1:0] {
        USC_ST_IDLE,
        USC_ST_COLLECT,
        USC_ST_HELD
    } usc_state_t;

    typedef logic [7:0] usc_byte_t;

endpackage

// file: design/usc_setup_capture.sv
// setup packet capture: collects the eight setup bytes and shows them over AXI4-Lite
// assumes the link logic delivers setup bytes in order, synchronous to clk_i
//
// What this block does
// [R1] request code readable at 0x484, bits 7:0
// [R2] value low byte readable at 0x488
// [R3] value high byte readable at 0x48C
// [R4] index low byte at 0x490, resets zero
// [R5] index high byte at 0x494, resets zero
// [R6] length low byte at 0x498, resets zero
// [R7] length high byte readable at 0x49C
// [R8] only standard request codes named; others passed
// [R9] attribute byte fields readable at 0x480
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`include "usc_regs.svh"

module usc_setup_capture #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // setup bytes from the link
    input  wire logic              setup_start_i,
    input  wire logic              setup_byte_valid_i,
    input  wire logic [7:0]        setup_byte_i,
    // capture events and decode
    output logic                   setup_done_o,
    output logic                   std_request_o,
    // axi4-lite write address
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    // axi4-lite write data
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    // axi4-lite write response
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic [1:0]             s_axi_bresp,
    // axi4-lite read address
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    // axi4-lite read data
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp
);

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int         NBYTES      = `USC_SETUP_BYTES;

    // reset release through two flops; the assert stays asynchronous
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // capture storage
    usc_pkg::usc_byte_t  shadow [NBYTES];
    usc_pkg::usc_byte_t  live   [NBYTES];
    logic [2:0]          byte_idx;
    usc_pkg::usc_state_t state;
    usc_pkg::usc_state_t next_state;
    logic [1:0]          control;
    logic                captured;
    logic                cut_short;
    logic                last_byte;
    logic                commit;
    logic                restart;

    // register-bus control
    logic                aw_got;
    logic                w_got;
    logic [ADDR_W-1:0]   wr_addr;
    logic [31:0]         wr_data;
    logic [3:0]          wr_strb;
    logic                wr_fire;
    logic                wr_mapped;
    logic                status_clear;
    logic [1:0]          clear_bits;
    logic [31:0]         rd_word;
    logic                rd_mapped;

    assign last_byte = setup_byte_valid_i && (byte_idx == 3'(NBYTES - 1));
    assign restart   = setup_start_i && setup_byte_valid_i;
    // a completed packet lands in the live copy only from the collect state, never while held
    assign commit    = last_byte && (state == usc_pkg::USC_ST_COLLECT) && !restart;

    // receive sequencer
    always_comb begin
        next_state = state;
        case (state)
            usc_pkg::USC_ST_IDLE: begin
                if (restart && control[`USC_CTRL_ENABLE]) begin
                    next_state = usc_pkg::USC_ST_COLLECT;
                end
            end
            usc_pkg::USC_ST_COLLECT: begin
                if (!control[`USC_CTRL_ENABLE]) begin
                    next_state = usc_pkg::USC_ST_IDLE;
                end else if (commit) begin
                    next_state = control[`USC_CTRL_HOLD] ? usc_pkg::USC_ST_HELD
                                                         : usc_pkg::USC_ST_IDLE;
                end
            end
            usc_pkg::USC_ST_HELD: begin
                // held until software clears the captured flag or the hold bit
                if (!captured || !control[`USC_CTRL_HOLD]) begin
                    next_state = usc_pkg::USC_ST_IDLE;
                end
            end
            default: begin
                next_state = usc_pkg::USC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= usc_pkg::USC_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // byte position within the packet; a start byte is always byte zero and sets the count to one
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            byte_idx <= 3'h0;
        end else if (restart) begin
            byte_idx <= 3'h1;
        end else if (setup_byte_valid_i && state == usc_pkg::USC_ST_COLLECT) begin
            byte_idx <= byte_idx + 3'h1;
        end else if (state != usc_pkg::USC_ST_COLLECT) begin
            byte_idx <= 3'h0;
        end
    end

    // per-byte shadow and live copies; live only changes on a whole packet,
    // so software never reads a mix of two packets
    for (genvar i = 0; i < NBYTES; i++) begin : g_byte
        always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
                shadow[i] <= `USC_RST_BYTE;
            end else if (setup_byte_valid_i && (restart ? (i == 0) : (byte_idx == 3'(i)))) begin
                shadow[i] <= setup_byte_i;
            end
        end

        always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
                live[i] <= `USC_RST_BYTE; // see [R4] see [R5] see [R6]
            end else if (commit) begin
                live[i] <= (i == NBYTES - 1) ? setup_byte_i : shadow[i];
            end
        end
    end

    // software clear of status: write one to clear
    assign status_clear = wr_fire && wr_mapped && wr_strb[0]
                          && (wr_addr[11:0] == `USC_OFS_STATUS);
    assign clear_bits   = status_clear ? wr_data[1:0] : 2'h0;

    // sticky captured flag; a new packet in the clearing cycle wins
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            captured <= 1'b0;
        end else if (commit) begin
            captured <= 1'b1;
        end else if (clear_bits[`USC_STAT_CAPTURED]) begin
            captured <= 1'b0;
        end
    end

    // sticky short-packet flag: a start arrived before eight bytes were seen
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cut_short <= 1'b0;
        end else if (restart && state == usc_pkg::USC_ST_COLLECT) begin
            cut_short <= 1'b1;
        end else if (clear_bits[`USC_STAT_SHORT]) begin
            cut_short <= 1'b0;
        end
    end

    // control word: enable and hold
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            control <= `USC_RST_CONTROL;
        end else if (wr_fire && wr_mapped && wr_strb[0]
                     && wr_addr[11:0] == `USC_OFS_CONTROL) begin
            control <= wr_data[1:0];
        end
    end

    // event pulse and standard-request decode of the committed packet
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            setup_done_o  <= 1'b0;
            std_request_o <= 1'b0;
        end else begin
            setup_done_o <= commit;
            if (commit) begin
                std_request_o <= is_standard(shadow[0], shadow[1]); // see [R8]
            end
        end
    end

    // standard type and a named code; anything else is left to software
    function automatic logic is_standard(input usc_pkg::usc_byte_t attr,
                                         input usc_pkg::usc_byte_t code);
        logic known;
        known = 1'b0;
        case (code)
            usc_pkg::USC_REQ_GET_STATUS,
            usc_pkg::USC_REQ_CLEAR_FEATURE,
            usc_pkg::USC_REQ_SET_FEATURE,
            usc_pkg::USC_REQ_SET_ADDRESS,
            usc_pkg::USC_REQ_GET_DESCRIPTOR,
            usc_pkg::USC_REQ_SET_DESCRIPTOR,
            usc_pkg::USC_REQ_GET_CONFIGURATION,
            usc_pkg::USC_REQ_SET_CONFIGURATION,
            usc_pkg::USC_REQ_GET_INTERFACE,
            usc_pkg::USC_REQ_SET_INTERFACE,
            usc_pkg::USC_REQ_SYNCH_FRAME: known = 1'b1;
            default: known = 1'b0;
        endcase
        return known && (attr[`USC_ATTR_TYPE_MSB:`USC_ATTR_TYPE_LSB]
                         == usc_pkg::USC_TYPE_STANDARD);
    endfunction

    // write channel: address and data taken in either order
    assign wr_fire   = aw_got && w_got && !s_axi_bvalid;
    assign wr_mapped = addr_mapped(wr_addr);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            aw_got        <= 1'b0;
            wr_addr       <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_got        <= 1'b1;
            wr_addr       <= s_axi_awaddr;
        end else if (!aw_got) begin
            s_axi_awready <= 1'b1;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_got        <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_wready <= 1'b0;
            w_got        <= 1'b0;
            wr_data      <= 32'h0000_0000;
            wr_strb      <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_got        <= 1'b1;
            wr_data      <= s_axi_wdata;
            wr_strb      <= s_axi_wstrb;
        end else if (!w_got) begin
            s_axi_wready <= 1'b1;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_got        <= 1'b0;
        end
    end

    // captured bytes are read only: writes to them are ignored but answered okay
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // word-aligned decode of the block's own window
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        logic [11:0] w;
        w = {a[11:2], 2'b00};
        return (w == `USC_OFS_STATUS) || (w == `USC_OFS_CONTROL)
               || (w >= `USC_OFS_ATTRIBUTES && w <= `USC_OFS_LENGTH_HIGH);
    endfunction

    // read mux; narrow fields sit in the low bits, upper bits read zero
    always_comb begin
        rd_word   = 32'h0000_0000;
        rd_mapped = 1'b1;
        case ({s_axi_araddr[11:2], 2'b00})
            `USC_OFS_ATTRIBUTES:   rd_word[7:0] = live[0]; // see [R9]
            `USC_OFS_REQUEST_CODE: rd_word[7:0] = live[1]; // see [R1]
            `USC_OFS_VALUE_LOW:    rd_word[7:0] = live[2]; // see [R2]
            `USC_OFS_VALUE_HIGH:   rd_word[7:0] = live[3]; // see [R3]
            `USC_OFS_INDEX_LOW:    rd_word[7:0] = live[4]; // see [R4]
            `USC_OFS_INDEX_HIGH:   rd_word[7:0] = live[5]; // see [R5]
            `USC_OFS_LENGTH_LOW:   rd_word[7:0] = live[6]; // see [R6]
            `USC_OFS_LENGTH_HIGH:  rd_word[7:0] = live[7]; // see [R7]
            `USC_OFS_STATUS:       rd_word[1:0] = {cut_short, captured};
            `USC_OFS_CONTROL:      rd_word[1:0] = control;
            default:               rd_mapped    = 1'b0;
        endcase
    end

    // read channel: one read outstanding, answer one cycle after the address
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// file: tb/usc_host_model.sv
// host side model: sends one setup packet, bytes 0..7, on request
// assumes send_i is a one-cycle pulse while busy_o is low
module usc_host_model (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // packet request
    input  wire logic        send_i,
    input  wire logic        slow_i,
    input  wire logic [63:0] pkt_i,
    output logic             busy_o,
    // byte stream
    output logic             start_o,
    output logic             valid_o,
    output logic [7:0]       byte_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0]  idx;
    logic        pause;
    logic [63:0] pkt;
    logic [7:0]  last;

    // idle line shows the inverse of the last byte, never a stale copy
    assign valid_o = busy_o && !pause;
    assign start_o = valid_o && idx == 3'h0;
    assign byte_o  = valid_o ? pkt[8*idx +: 8] : ~last;

    // slow mode leaves one idle cycle after each byte
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_o <= 1'b0;
            idx    <= 3'h0;
            pause  <= 1'b0;
            pkt    <= 64'h0;
            last   <= 8'h0;
        end else if (!busy_o) begin
            busy_o <= send_i;
            idx    <= 3'h0;
            pause  <= 1'b0;
            pkt    <= pkt_i;
        end else if (pause) begin
            pause <= 1'b0;
        end else begin
            last   <= byte_o;
            idx    <= idx + 3'h1;
            pause  <= slow_i;
            busy_o <= idx != 3'h7;
        end
    end
endmodule

// file: tb/usc_setup_capture_sva.sv
// checker for the setup capture block, bound to its top ports
// assumes one clock domain and the register map at 0x478..0x49C
module usc_chk #(
    parameter int ADDR_W = 12
) (
    input wire logic              clk_i,
    input wire logic              rst_n_i,
    input wire logic              setup_byte_valid_i,
    input wire logic              setup_done_o,
    input wire logic              std_request_o,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_bvalid,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [ADDR_W-1:0] ra;
    logic [ADDR_W-1:0] wa;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // addresses of the transfers in flight
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ra <= '0;
            wa <= '0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
            if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
        end
    end

    AST_RD_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_RD_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_RD_MAPPED: assert property (
        s_axi_rvalid && ra >= 12'h480 && ra <= 12'h49F |-> s_axi_rresp == 2'h0)
        else $error("byte register read refused");
    AST_RD_UNMAPPED: assert property (
        s_axi_rvalid && (ra < 12'h478 || ra > 12'h49F)
        |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read answered");
    AST_WR_OKAY: assert property (
        s_axi_bvalid && wa >= 12'h480 && wa <= 12'h49F |-> s_axi_bresp == 2'h0)
        else $error("byte register write refused");
    AST_DONE_PULSE: assert property (setup_done_o |=> !setup_done_o)
        else $error("done longer than one cycle");
    AST_DONE_CAUSE: assert property (setup_done_o |-> $past(setup_byte_valid_i))
        else $error("done without a last byte");
    AST_STD_EDGE: assert property ($changed(std_request_o) |-> setup_done_o)
        else $error("decode changed between packets");

    cover property (setup_done_o && std_request_o);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    cover property (s_axi_rvalid && !s_axi_rready);
endmodule

bind usc_setup_capture usc_chk #(.ADDR_W(ADDR_W)) i_usc_chk (
    .clk_i, .rst_n_i, .setup_byte_valid_i, .setup_done_o, .std_request_o,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_bvalid, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp
);

// file: tb/testbench.sv
// self-checking bench: host model feeds packets, reads go over axi4-lite
// assumes the checker is bound from its own file
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i, rst_n_i, send, slow, busy;
    logic        setup_start_i, setup_byte_valid_i, setup_done_o, std_request_o;
    logic [7:0]  setup_byte_i;
    logic [63:0] pkt, p;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    int          errors, num_checks, n;

    usc_setup_capture i_usc_setup_capture (
        .clk_i, .rst_n_i, .setup_start_i, .setup_byte_valid_i, .setup_byte_i,
        .setup_done_o, .std_request_o, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp
    );

    usc_host_model i_usc_host_model (
        .clk_i, .rst_n_i, .send_i(send), .slow_i(slow), .pkt_i(pkt), .busy_o(busy),
        .start_o(setup_start_i), .valid_o(setup_byte_valid_i), .byte_o(setup_byte_i)
    );

    // 125 MHz
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // standard type with a named code
    function automatic logic std_exp(input logic [7:0] attr, input logic [7:0] code);
        return attr[6:5] == 2'h0 && code <= 8'h0C && code != 8'h02 && code != 8'h04;
    endfunction

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    // rready comes zero to two cycles late at random so the slave sometimes must hold its answer
    task automatic axi_rd(input logic [11:0] a);
        @(posedge clk_i);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        do @(posedge clk_i); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        repeat ($urandom % 3) @(posedge clk_i);
        s_axi_rready <= 1'b1;
        do @(posedge clk_i); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
        logic aw, w;
        aw = 1'b0;
        w  = 1'b0;
        @(posedge clk_i);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= v;
        s_axi_bready  <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk_i);
            if (s_axi_awvalid && s_axi_awready) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk_i); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // all eight byte registers against the expected packet
    task automatic read_all(input logic [63:0] exp);
        for (int i = 0; i < 8; i++) begin
            axi_rd(12'h480 + 12'(4 * i));
            chk_data(d, {24'h0, exp[8*i +: 8]});
            chk_data({30'h0, r}, 32'h0);
        end
    endtask

    // hands one packet to the host model and waits for the done pulse or 40 cycles
    task automatic send_pkt(input logic [63:0] v, input logic s);
        slow <= s;
        pkt  <= v;
        send <= 1'b1;
        @(posedge clk_i);
        send <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (setup_done_o !== 1'b1 && n < 40);
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // hang guard, well beyond the expected run
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        give_verdict;
    end

    initial begin
        {rst_n_i, send, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        pkt = 64'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        errors = 0;
        num_checks = 0;
        n = $urandom(10802);
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        read_all(64'h0);
        $display("test reset values done");
        // first eleven packets walk every named code, the rest are random
        for (int k = 0; k < 16; k++) begin
            p = {$urandom, $urandom};
            if (k < 11) begin
                p[15:8] = (k < 2) ? 8'(k) : (k == 2) ? 8'h03 : 8'(k + 2);
                p[6:5]  = 2'h0;
            end
            send_pkt(p, k[0]);
            chk_bit(setup_done_o, 1'b1);
            chk_bit(std_request_o, std_exp(p[7:0], p[15:8]));
            read_all(p);
        end
        $display("test packets done");
        // hold mode: the next packet stays out until software clears captured
        p = ~p;
        axi_wr(12'h47C, 32'h3);
        chk_data({30'h0, r}, 32'h0);
        send_pkt(p, 1'b0);
        chk_bit(setup_done_o, 1'b1);
        send_pkt(~p, 1'b1);
        chk_bit(setup_done_o, 1'b0);
        read_all(p);
        axi_rd(12'h478);
        chk_data(d, 32'h1);
        axi_wr(12'h478, 32'h3);
        axi_wr(12'h47C, 32'h1);
        axi_rd(12'h478);
        chk_data(d, 32'h0);
        $display("test hold done");
        axi_rd(12'h4A0);
        chk_data({30'h0, r}, 32'h2);
        chk_data(d, 32'h0);
        for (int i = 0; i < 8; i++) begin
            axi_wr(12'h480 + 12'(4 * i), $urandom);
            chk_data({30'h0, r}, 32'h0);
        end
        read_all(p);
        $display("test read only done");
        give_verdict;
    end
endmodule
